// >>> hw/asr_baud.sv
// Divider that makes the sixteen-times bit clock enable.
`timescale 1ns/1ps
module asr_baud (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] divisor,
    input wire logic high_speed,
    input wire logic clear,
    output logic tick
);
    import asr_pkg::*;
    typedef struct packed {
        logic [1:0] pre;
        logic [7:0] cnt;
    } asr_baud_state_t;
    asr_baud_state_t s;
    asr_baud_state_t next_s;
    logic pre_done;

    // Low speed divides by four more, giving sixty-four clocks per bit per divisor step.
    assign pre_done = high_speed || (s.pre == PRESCALE_LAST);
    assign tick = !clear && pre_done && (s.cnt == divisor);

    always_comb begin
        next_s = s;
        if (clear) begin
            next_s = '0;
        end else begin
            next_s.pre = high_speed ? 2'h0 : s.pre + 2'h1;
            if (pre_done) begin
                next_s.cnt = (s.cnt == divisor) ? 8'h00 : s.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    chk_clear_restart: assert property (@(posedge clk) disable iff (!reset_n)
        clear |=> (s.cnt == 8'h00) && (s.pre == 2'h0))
        else $error("baud timer not cleared");
endmodule // asr_baud

// >>> hw/asr_fifo_if.sv
// Link between the receiver and its word queue.
`timescale 1ns/1ps
interface asr_fifo_if #(parameter int W = 10);
    logic push;
    logic [W-1:0] wdata;
    logic full;
    logic pop;
    logic [W-1:0] rdata;
    logic empty;
    modport producer(output push, output wdata, output pop, input full, input rdata, input empty);
    modport store(input push, input wdata, input pop, output full, output rdata, output empty);
endinterface

// >>> hw/asr_pkg.sv
// Register map, field positions, reset values and encodings of the serial port.
package asr_pkg;
    // ==========================================================
    // Bus and register indices; the byte address is four times the index.
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h00c;
    localparam logic [IDX_W-1:0] IDX_RX_CTRL = 10'h018;
    localparam logic [IDX_W-1:0] IDX_TX_BUF = 10'h019;
    localparam logic [IDX_W-1:0] IDX_RX_BUF = 10'h01a;
    localparam logic [IDX_W-1:0] IDX_ENABLES = 10'h08c;
    localparam logic [IDX_W-1:0] IDX_TX_CTRL = 10'h098;
    localparam logic [IDX_W-1:0] IDX_BAUD = 10'h099;
    // ==========================================================
    // Field positions.
    localparam int FLAG_TX = 4;
    localparam int FLAG_RX = 5;
    localparam int RC_SERIAL_PORT_ENABLE = 7;
    localparam int RC_RX9 = 6;
    localparam int RC_CONTINUOUS_RX_ENABLE = 4;
    localparam int RC_FRAMING_ERROR = 2;
    localparam int RC_OVERRUN_ERROR = 1;
    localparam int RC_RX_NINTH_BIT = 0;
    localparam int TC_TX9 = 6;
    localparam int TC_TX_ENABLE = 5;
    localparam int TC_SYNC = 4;
    localparam int TC_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int TC_TX_SHIFTER_EMPTY = 1;
    localparam int TC_TX_NINTH_BIT = 0;
    localparam int ENTRY_N9 = 8;
    localparam int ENTRY_FRAMING_ERROR = 9;
    // ==========================================================
    // Writable masks and reset values.
    localparam logic [7:0] RX_CTRL_WMASK = 8'hf0;
    localparam logic [7:0] TX_CTRL_WMASK = 8'hf5;
    localparam logic [7:0] ENABLES_WMASK = 8'h30;
    localparam logic [7:0] RST_RX_CTRL = 8'h00;
    localparam logic [7:0] RST_TX_CTRL = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_BAUD = 8'h00;
    localparam logic [7:0] RST_TX_BUF = 8'h00;
    // ==========================================================
    // Timing counts: prescale in clocks, phases in ticks of the sixteen-times bit clock, frame lengths in bits.
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [3:0] PHASE_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_FIRST = 4'h7;
    localparam logic [3:0] SAMPLE_MID = 4'h8;
    localparam logic [3:0] SAMPLE_LAST = 4'h9;
    localparam logic [3:0] TX_BITS_8 = 4'ha;
    localparam logic [3:0] TX_BITS_9 = 4'hb;
    localparam logic [3:0] RX_STOP_8 = 4'h9;
    localparam logic [3:0] RX_STOP_9 = 4'ha;
    localparam int FIFO_DEPTH = 2;
    localparam int RX_ENTRY_W = 10;
    typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SHIFT = 3'b100} asr_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_FRAME = 2'b10} asr_rx_state_t;
endpackage

// >>> hw/asr_rx_fifo.sv
// Small word queue for received entries.
`timescale 1ns/1ps
module asr_rx_fifo #(
    parameter int W = 10,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic reset_n,
    asr_fifo_if.store f
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] count;
    } asr_fifo_state_t;
    asr_fifo_state_t s;
    asr_fifo_state_t next_s;
    logic do_push;
    logic do_pop;

    assign f.full = (s.count == CNT_FULL);
    assign f.empty = (s.count == '0);
    assign f.rdata = s.mem[s.rptr];

    always_comb begin
        next_s = s;
        do_pop = f.pop && !f.empty;
        do_push = f.push && (!f.full || do_pop);
        if (do_push) begin
            next_s.mem[s.wptr] = f.wdata;
            next_s.wptr = (s.wptr == PTR_LAST) ? '0 : s.wptr + 1'b1;
        end
        if (do_pop) begin
            next_s.rptr = (s.rptr == PTR_LAST) ? '0 : s.rptr + 1'b1;
        end
        if (do_push && !do_pop) begin
            next_s.count = s.count + 1'b1;
        end else if (do_pop && !do_push) begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // asr_rx_fifo

// >>> hw/asr_serial.sv
// Serial port top: AHB-Lite register slave, transmitter and receiver.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module asr_serial (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [asr_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic receive_pin,
    output logic transmit_pin_out,
    output logic transmit_pin_oe,
    output logic irq
);
    import asr_pkg::*;

    typedef struct packed {
        logic [7:0] rx_ctrl;
        logic [7:0] tx_ctrl;
        logic [7:0] enables;
        logic [7:0] baud_div;
        logic [7:0] tx_buf;
        logic buf_full;
        logic tx_buffer_empty_flag;
        logic tx_enable_d;
        asr_tx_state_t tx_state;
        logic [10:0] tx_sr;
        logic [3:0] tx_bits;
        logic [3:0] tx_phase;
        asr_rx_state_t rx_state;
        logic [3:0] rx_phase;
        logic [3:0] rx_bits;
        logic [8:0] rx_shift_reg;
        logic [1:0] votes;
        logic overrun_error;
        logic wr_pend;
        logic [IDX_W-1:0] wr_idx;
        logic [7:0] rdata;
    } asr_state_t;

    asr_state_t s;
    asr_state_t next_s;
    asr_fifo_if #(.W(RX_ENTRY_W)) fifo();

    logic take;
    logic [IDX_W-1:0] idx;
    logic wr_tx;
    logic wr_baud;
    logic rd_rx;
    logic async_on;
    logic tx_enable_on;
    logic rx_on;
    logic tick;
    logic baud_clear;
    logic load;
    logic maj;
    logic stop_now;
    logic [7:0] flags_view;
    logic [7:0] rx_view;
    logic [7:0] tx_view;

    // ==========================================================
    // Baud generator and receive queue.
    assign baud_clear = wr_baud || !(tx_enable_on || rx_on);

    asr_baud u_baud (
        .clk(clk),
        .reset_n(reset_n),
        .divisor(s.baud_div),
        .high_speed(s.tx_ctrl[TC_HIGH_SPEED_BAUD_SELECT]),
        .clear(baud_clear),
        .tick(tick)
    );

    asr_rx_fifo #(.W(RX_ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .f(fifo.store)
    );

    // ==========================================================
    // Outputs.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = {24'h000000, s.rdata};
    assign transmit_pin_out = s.tx_sr[0];
    assign transmit_pin_oe = tx_enable_on;
    assign irq = (s.tx_buffer_empty_flag && s.enables[FLAG_TX]) || (!fifo.empty && s.enables[FLAG_RX]);

    // ==========================================================
    // Next-state logic.
    always_comb begin
        next_s = s;
        idx = haddr[ADDR_W-1:2];
        take = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);
        wr_tx = s.wr_pend && (s.wr_idx == IDX_TX_BUF);
        wr_baud = s.wr_pend && (s.wr_idx == IDX_BAUD);
        rd_rx = take && !hwrite && (idx == IDX_RX_BUF);
        async_on = s.rx_ctrl[RC_SERIAL_PORT_ENABLE] && !s.tx_ctrl[TC_SYNC];
        tx_enable_on = async_on && s.tx_ctrl[TC_TX_ENABLE];
        rx_on = async_on && s.rx_ctrl[RC_CONTINUOUS_RX_ENABLE];
        maj = (s.votes[0] && s.votes[1]) || (receive_pin && (s.votes[0] || s.votes[1]));
        stop_now = 1'b0;
        fifo.push = 1'b0;
        fifo.pop = rd_rx;
        fifo.wdata = '0;

        flags_view = 8'h00;
        flags_view[FLAG_TX] = s.tx_buffer_empty_flag;
        flags_view[FLAG_RX] = !fifo.empty;
        rx_view = s.rx_ctrl & RX_CTRL_WMASK;
        rx_view[RC_FRAMING_ERROR] = fifo.rdata[ENTRY_FRAMING_ERROR];
        rx_view[RC_OVERRUN_ERROR] = s.overrun_error;
        rx_view[RC_RX_NINTH_BIT] = fifo.rdata[ENTRY_N9];
        tx_view = s.tx_ctrl & TX_CTRL_WMASK;
        tx_view[TC_TX_SHIFTER_EMPTY] = (s.tx_state == TX_IDLE);

        // Register bus: reads are answered at the address phase, writes land in the data phase.
        next_s.wr_pend = take && hwrite;
        next_s.wr_idx = idx;
        if (take && !hwrite) begin
            case (idx)
                IDX_FLAGS: next_s.rdata = flags_view;
                IDX_RX_CTRL: next_s.rdata = rx_view;
                IDX_TX_BUF: next_s.rdata = s.tx_buf;
                IDX_RX_BUF: next_s.rdata = fifo.rdata[7:0];
                IDX_ENABLES: next_s.rdata = s.enables;
                IDX_TX_CTRL: next_s.rdata = tx_view;
                IDX_BAUD: next_s.rdata = s.baud_div;
                default: next_s.rdata = 8'h00;
            endcase
        end
        if (s.wr_pend) begin
            case (s.wr_idx)
                IDX_RX_CTRL: next_s.rx_ctrl = hwdata[7:0] & RX_CTRL_WMASK;
                IDX_ENABLES: next_s.enables = hwdata[7:0] & ENABLES_WMASK;
                IDX_TX_CTRL: next_s.tx_ctrl = hwdata[7:0] & TX_CTRL_WMASK;
                IDX_BAUD: next_s.baud_div = hwdata[7:0];
                default: ;
            endcase
        end

        // Transmitter: the buffer moves into the shifter only when the shifter is idle.
        next_s.tx_enable_d = s.tx_ctrl[TC_TX_ENABLE];
        if (s.tx_ctrl[TC_TX_ENABLE] && !s.tx_enable_d) begin
            next_s.tx_buffer_empty_flag = 1'b1;
        end
        load = s.buf_full && (s.tx_state == TX_IDLE) && tx_enable_on;
        if (load) begin
            // Bit zero stays high until the first tick drops it to the start bit.
            next_s.tx_sr = {1'b1, s.tx_ctrl[TC_TX9] ? s.tx_ctrl[TC_TX_NINTH_BIT] : 1'b1, s.tx_buf, 1'b1};
            next_s.tx_bits = s.tx_ctrl[TC_TX9] ? TX_BITS_9 : TX_BITS_8;
            next_s.tx_state = TX_WAIT;
            next_s.buf_full = 1'b0;
            next_s.tx_buffer_empty_flag = 1'b1;
        end
        case (s.tx_state)
            TX_IDLE: begin
                next_s.tx_phase = 4'h0;
            end
            TX_WAIT: begin
                if (tick) begin
                    next_s.tx_state = TX_SHIFT;
                    next_s.tx_sr[0] = 1'b0;
                    next_s.tx_phase = 4'h0;
                end
            end
            TX_SHIFT: begin
                if (tick) begin
                    next_s.tx_phase = s.tx_phase + 4'h1;
                    if (s.tx_phase == PHASE_LAST) begin
                        next_s.tx_sr = {1'b1, s.tx_sr[10:1]};
                        next_s.tx_bits = s.tx_bits - 4'h1;
                        if (s.tx_bits == 4'h1) begin
                            next_s.tx_state = TX_IDLE;
                        end
                    end
                end
            end
            default: begin
                next_s.tx_state = TX_IDLE;
            end
        endcase
        if (!tx_enable_on) begin
            next_s.tx_state = TX_IDLE;
            next_s.tx_sr = '1;
        end
        if (wr_tx) begin
            next_s.tx_buf = hwdata[7:0];
            next_s.buf_full = 1'b1;
            next_s.tx_buffer_empty_flag = 1'b0;
        end

        // Receiver: a low level on a tick opens a frame; each bit is voted at its middle.
        case (s.rx_state)
            RX_IDLE: begin
                if (tick && !receive_pin) begin
                    next_s.rx_state = RX_FRAME;
                    next_s.rx_phase = 4'h1;
                    next_s.rx_bits = 4'h0;
                end
            end
            RX_FRAME: begin
                if (tick) begin
                    next_s.rx_phase = s.rx_phase + 4'h1;
                    if (s.rx_phase == SAMPLE_FIRST || s.rx_phase == SAMPLE_MID) begin
                        next_s.votes = {s.votes[0], receive_pin};
                    end
                    if (s.rx_phase == SAMPLE_LAST) begin
                        next_s.rx_bits = s.rx_bits + 4'h1;
                        if (s.rx_bits == 4'h0) begin
                            if (maj) begin
                                next_s.rx_state = RX_IDLE;
                            end
                        end else if (s.rx_bits == (s.rx_ctrl[RC_RX9] ? RX_STOP_9 : RX_STOP_8)) begin
                            stop_now = 1'b1;
                            next_s.rx_state = RX_IDLE;
                        end else begin
                            next_s.rx_shift_reg = {maj, s.rx_shift_reg[8:1]};
                        end
                    end
                end
            end
            default: begin
                next_s.rx_state = RX_IDLE;
            end
        endcase
        if (stop_now) begin
            if (s.rx_ctrl[RC_RX9]) begin
                fifo.wdata = {!maj, s.rx_shift_reg};
            end else begin
                fifo.wdata = {!maj, 1'b0, s.rx_shift_reg[8:1]};
            end
            if (fifo.full && !rd_rx) begin
                next_s.overrun_error = 1'b1;
            end else begin
                fifo.push = !s.overrun_error;
            end
        end
        if (!rx_on) begin
            next_s.rx_state = RX_IDLE;
            next_s.overrun_error = 1'b0;
            fifo.push = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.rx_ctrl <= RST_RX_CTRL;
            s.tx_ctrl <= RST_TX_CTRL;
            s.enables <= RST_ENABLES;
            s.baud_div <= RST_BAUD;
            s.tx_buf <= RST_TX_BUF;
            s.tx_state <= TX_IDLE;
            s.rx_state <= RX_IDLE;
            s.tx_sr <= '1;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Checks.
    chk_load_sets_flag: assert property (@(posedge clk) disable iff (!reset_n)
        load && !wr_tx |=> s.tx_buffer_empty_flag && !s.buf_full && (s.tx_state == TX_WAIT))
        else $error("buffer move did not set transmit flag");
    chk_write_clears_flag: assert property (@(posedge clk) disable iff (!reset_n)
        wr_tx |=> !s.tx_buffer_empty_flag && s.buf_full)
        else $error("buffer write did not clear transmit flag");
    chk_enable_sets_flag: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(s.tx_ctrl[TC_TX_ENABLE]) && !wr_tx |=> s.tx_buffer_empty_flag)
        else $error("transmit enable did not set flag");
    chk_busy_holds_buffer: assert property (@(posedge clk) disable iff (!reset_n)
        (s.tx_state != TX_IDLE) && s.buf_full && tx_enable_on |=> s.buf_full)
        else $error("shifter reloaded before stop bit ended");
    chk_abort_floats: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(s.tx_ctrl[TC_TX_ENABLE]) |-> !transmit_pin_oe ##1 (s.tx_state == TX_IDLE))
        else $error("transmit abort incomplete");
    chk_idle_mark: assert property (@(posedge clk) disable iff (!reset_n)
        (s.tx_state != TX_SHIFT) && transmit_pin_oe |-> transmit_pin_out)
        else $error("idle transmit line not high");
    chk_start_bit_low: assert property (@(posedge clk) disable iff (!reset_n)
        (s.tx_state == TX_WAIT) && tick && tx_enable_on |=> !transmit_pin_out)
        else $error("start bit not low");
    chk_overrun_blocks: assert property (@(posedge clk) disable iff (!reset_n)
        s.overrun_error |-> !fifo.push)
        else $error("queue written while overrun set");
    chk_enable_clears_overrun: assert property (@(posedge clk) disable iff (!reset_n)
        !rx_on |=> !s.overrun_error)
        else $error("overrun survived receive reset");
    chk_full_sets_overrun: assert property (@(posedge clk) disable iff (!reset_n)
        stop_now && rx_on && fifo.full && !rd_rx |=> s.overrun_error)
        else $error("overrun not flagged");
    chk_irq_gating: assert property (@(posedge clk) disable iff (!reset_n)
        !s.enables[FLAG_TX] && !s.enables[FLAG_RX] |-> !irq)
        else $error("interrupt raised while both enables clear");
endmodule // asr_serial

// >>> verif/asr_remote.sv
// Remote serial terminal model: sends frames to the receiver and decodes the transmit line.
`timescale 1ns/1ps
module asr_remote (
    input wire logic clk,
    input wire logic line,
    output logic rx_line
);
    // ==========================================================
    // Frame timing, format and captured frames.
    int bitlen = 16;
    logic nine = 1'b0;
    logic [9:0] got[$];
    initial rx_line = 1'b1;
    // Start low, data LSB first, optional ninth bit, stop at the chosen level, then one idle bit.
    task automatic send(input logic [7:0] d, input logic n9, input logic use9, input logic stop);
        logic [10:0] f;
        f = use9 ? {stop, n9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        for (int i = 0; i < (use9 ? 11 : 10); i++) begin
            rx_line <= f[i];
            repeat (bitlen) @(posedge clk);
        end
        rx_line <= 1'b1;
        repeat (bitlen) @(posedge clk);
    endtask
    // Decodes each frame at mid-bit; stop level lands in bit 9, ninth bit in bit 8.
    initial begin
        logic [9:0] w;
        forever begin
            @(posedge clk);
            if (line === 1'b0) begin
                repeat (bitlen / 2) @(posedge clk);
                w = 10'h000;
                for (int i = 0; i < (nine ? 10 : 9); i++) begin
                    repeat (bitlen) @(posedge clk);
                    w[i] = line;
                end
                if (!nine) begin
                    w[9] = w[8];
                    w[8] = 1'b0;
                end
                got.push_back(w);
            end
        end
    end
endmodule // asr_remote

// >>> verif/asr_serial_bench.sv
// Self-checking testbench of the serial port with a remote terminal model.
`timescale 1ns/1ps
module asr_serial_bench;
    import asr_pkg::*;
    // ==========================================================
    // Signals, model queues and counters.
    logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0, hrdata, r;
    logic hreadyout, hresp, tx_out, tx_oe, irq, rx_line, line;
    logic [9:0] exp_tx[$];
    logic [7:0] exp_rx[$], b;
    int num_errors = 0, n_tests = 0, seed = 32'h0030;
    localparam logic [11:0] A_FLAGS = {IDX_FLAGS, 2'b00}, A_RXC = {IDX_RX_CTRL, 2'b00}, A_TXB = {IDX_TX_BUF, 2'b00};
    localparam logic [11:0] A_RXD = {IDX_RX_BUF, 2'b00}, A_EN = {IDX_ENABLES, 2'b00}, A_TXC = {IDX_TX_CTRL, 2'b00};
    localparam logic [11:0] A_BAUD = {IDX_BAUD, 2'b00};
    // The transmit line has a pull-up while the port does not drive it.
    assign line = tx_oe ? tx_out : 1'b1;
    asr_serial u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .receive_pin(rx_line), .transmit_pin_out(tx_out), .transmit_pin_oe(tx_oe), .irq(irq));
    asr_remote u_rem (.clk(clk), .line(line), .rx_line(rx_line));
    initial begin
        forever #20 clk = ~clk;
    end
    // ==========================================================
    // Bus, compare and closing tasks.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input string nm, input logic [7:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, r, {24'h0, exp});
        chk("okay response", hresp, 32'h0);
    endtask
    task automatic send_tx(input logic n9);
        b = $random(seed);
        exp_tx.push_back({1'b1, n9, b});
        bus(1'b1, A_TXB, {24'h0, b});
    endtask
    task automatic waitq(input int n);
        for (int i = 0; i < 3000 && u_rem.got.size() < n; i++) @(posedge clk);
        chk("frames seen", u_rem.got.size() >= n, 32'h1);
        repeat (u_rem.bitlen) @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        num_errors++;
        test_done;
    end
    // ==========================================================
    // Main sequence.
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(A_TXC, "tx ctrl reset", 8'h02);
        rd(A_FLAGS, "flags reset", 8'h00);
        rd(12'h004, "unmapped", 8'h00);
        bus(1'b1, A_BAUD, 32'h0);
        bus(1'b1, A_RXC, 32'h90);
        bus(1'b1, A_EN, 32'h10);
        bus(1'b1, A_TXC, 32'h24);
        rd(A_FLAGS, "tx flag on enable", 8'h10);
        chk("irq tx", irq, 32'h1);
        chk("idle mark", {tx_oe, tx_out}, 32'h3);
        bus(1'b1, A_EN, 32'h00);
        @(negedge clk);
        chk("irq masked", irq, 32'h0);
        send_tx(1'b0);
        send_tx(1'b0);
        rd(A_FLAGS, "flag with word waiting", 8'h00);
        rd(A_TXC, "shifter busy", 8'h24);
        waitq(2);
        rd(A_TXC, "shifter empty", 8'h26);
        rd(A_FLAGS, "flag after move", 8'h10);
        bus(1'b1, A_TXC, 32'h65);
        u_rem.nine = 1'b1;
        send_tx(1'b1);
        waitq(3);
        u_rem.nine = 1'b0;
        u_rem.bitlen = 64;
        bus(1'b1, A_TXC, 32'h20);
        send_tx(1'b0);
        waitq(4);
        u_rem.bitlen = 32;
        bus(1'b1, A_TXC, 32'h24);
        bus(1'b1, A_BAUD, 32'h1);
        send_tx(1'b0);
        waitq(5);
        u_rem.bitlen = 16;
        bus(1'b1, A_BAUD, 32'h0);
        while (exp_tx.size() > 0) chk("tx frame", u_rem.got.pop_front(), exp_tx.pop_front());
        bus(1'b1, A_EN, 32'h20);
        for (int k = 0; k < 3; k++) begin
            b = $random(seed);
            if (k < 2) exp_rx.push_back(b);
            u_rem.send(b, 1'b0, 1'b0, 1'b1);
        end
        chk("irq rx", irq, 32'h1);
        rd(A_RXC, "overrun", 8'h92);
        rd(A_FLAGS, "rx available", 8'h30);
        repeat (2) rd(A_RXD, "rx word", exp_rx.pop_front());
        rd(A_FLAGS, "rx drained", 8'h10);
        u_rem.send(8'h5a, 1'b0, 1'b0, 1'b1);
        rd(A_RXC, "overrun held", 8'h92);
        rd(A_FLAGS, "overrun blocks queue", 8'h10);
        bus(1'b1, A_RXC, 32'h80);
        u_rem.send(8'h3c, 1'b0, 1'b0, 1'b1);
        rd(A_FLAGS, "rx disabled", 8'h10);
        bus(1'b1, A_RXC, 32'hd0);
        rd(A_RXC, "overrun cleared", 8'hd0);
        for (int k = 0; k < 2; k++) begin
            b = $random(seed);
            exp_rx.push_back(b);
            u_rem.send(b, k == 0, 1'b1, k != 0);
        end
        rd(A_RXC, "head framing and ninth", 8'hd5);
        rd(A_RXD, "rx ninth word", exp_rx.pop_front());
        rd(A_RXC, "next entry status", 8'hd0);
        rd(A_RXD, "rx last word", exp_rx.pop_front());
        send_tx(1'b0);
        repeat (40) @(posedge clk);
        bus(1'b1, A_TXC, 32'h04);
        @(negedge clk);
        chk("pin released", tx_oe, 32'h0);
        rd(A_TXC, "abort resets shifter", 8'h06);
        test_done;
    end
endmodule // asr_serial_bench
